// ---- swmon_pkg.sv ----
// Constants and state type shared by the switch monitor serial port.
// Assumes a 200 MHz clk; every link pin is sampled, never used as a clock.
// How it works
// - Link is live only while chip select is low; otherwise output floats.
// - CRC covers frame bits 39..8 and sits in bits 7..0.
// - Bad CRC, length or direction drops the frame and flags an error.
// - Input bits shift in on each falling serial clock edge.
// - Status reply: 100, factors, 0, mode, 22 switch bits, CRC.
// - A factor bit reads 1 once its cause has occurred.
// - Mode bit reads 0 in normal and 1 in sleep.
// - Switch bits read 1 for closed, 0 for open.
// - Reply snapshot at chip select fall, shifted out on rising clock.
// - Readback reply: 100, factors, 24-bit value, CRC.
// - A read result comes back in the following frame's reply.
// - Back-to-back reads each return the previous one; null collects last.
// - Interrupt is low straight after reset.
// - Chip select rise ending a frame clears the factors it reported; the interrupt is released only if no factor remains.
// - A switch change pulls the interrupt low.
// - A switch with its source off is floating; its bit keeps the last value seen with source on.
// - Switches are sampled only while their source is on.
// - Mode command bit 1 enters sleep, 0 returns to normal.
// - Wake output floats in sleep and is driven low in normal.
// - With auto wake, a switch change in sleep returns to normal.
// - Valid frames start with direction code 01; others are errors.
// - Five factors: test, thermal, reset, communication error, switch.
// - A factor raised during a frame survives its end and shows next.
`default_nettype none

package swmon_pkg;

   localparam int FRAME_BITS = 40;
   localparam logic [6:0] FRAME_LEN = 7'h28;
   localparam logic [6:0] FRAME_CNT_MAX = 7'h29;
   localparam logic [1:0] DIR_HOST = 2'h1;
   localparam logic [2:0] REPLY_HEAD = 3'h4;
   localparam int NUM_SW = 22;

   localparam logic [7:0] CRC_POLY = 8'h2F;
   localparam logic [7:0] CRC_INIT = 8'hFF;

   // Factor positions within the 5-bit factor field (frame bits 36..32)
   localparam int FLAG_TEST = 4;
   localparam int FLAG_THERM = 3;
   localparam int FLAG_RST = 2;
   localparam int FLAG_ERR = 1;
   localparam int FLAG_SW = 0;
   localparam logic [4:0] FLAGS_RESET = 5'h04;

   // Address bit 5 marks a readback request of the register in bits 4..0
   localparam int ADDR_READ_BIT = 5;
   localparam logic [5:0] ADDR_NULL = 6'h00;
   localparam logic [5:0] ADDR_AUTO = 6'h0E;
   localparam logic [5:0] ADDR_MODE = 6'h0F;
   localparam int DATA_CTRL_BIT = 23;

   // Synchroniser lanes
   localparam int SY_CS = 0;
   localparam int SY_SCLK = 1;
   localparam int SY_SI = 2;
   localparam int SY_TEST = 3;
   localparam int SY_THERM = 4;
   localparam int SY_SW = 5;
   localparam int SY_W = 27;
   localparam logic [26:0] SY_INIT = 27'h000_0001;

   typedef struct packed {
      logic cs_prev;
      logic sclk_prev;
      logic [39:0] rx;
      logic [6:0] bit_cnt;
      logic [39:0] tx;
      logic so;
      logic so_oe;
      logic [4:0] flags;
      logic [4:0] rep_flags;
      logic [21:0] sw_state;
      logic sleep;
      logic auto_wake;
      logic rd_pending;
      logic [5:0] rd_addr;
      logic int_oe;
      logic wake_oe;
      logic pin_low;
      logic wr_strobe;
      logic [5:0] wr_addr;
      logic [23:0] wr_data;
   } port_state_s;

endpackage : swmon_pkg

`default_nettype wire

// ---- level_sync.sv ----
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit is independent; no bus coherence is promised.
`default_nettype none

module level_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         meta <= INIT;
         sync_out <= INIT;
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule : level_sync

`default_nettype wire

// ---- frame_crc8.sv ----
// Combinational CRC-8 over the 32 upper bits of a frame, MSB first.
// Assumes both link ends use the same polynomial and seed.
`default_nettype none

module frame_crc8 (
   input wire logic [31:0] data,
   output logic [7:0] crc
);

   always_comb
   begin
      logic [7:0] c;
      logic fb;
      c = swmon_pkg::CRC_INIT;
      fb = 1'b0;
      for (int i = 31; i >= 0; i--)
      begin
         fb = c[7] ^ data[i];
         c = {c[6:0], 1'b0};
         if (fb)
         begin
            c = c ^ swmon_pkg::CRC_POLY;
         end
      end
      crc = c;
   end

endmodule : frame_crc8

`default_nettype wire

// ---- switch_monitor_serial_frame_port.sv ----
// Serial frame port of the switch monitor: receive, check, reply, interrupt.
// Assumes link pins and fault levels are asynchronous; source_on and
// ext_rd_data come from logic on clk.
`default_nettype none

module switch_monitor_serial_frame_port (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic chip_select_n,
   input wire logic sclk,
   input wire logic si,
   input wire logic [5:0] high_supply_inputs,
   input wire logic [7:0] source_only_inputs,
   input wire logic [7:0] bidir_current_inputs,
   input wire logic [21:0] source_on,
   input wire logic test_mode_in,
   input wire logic thermal_shutdown_in,
   input wire logic [23:0] ext_rd_data,
   output logic so,
   output logic so_oe,
   output logic int_n_out,
   output logic int_n_oe,
   output logic wake_out_n,
   output logic wake_out_n_oe,
   output logic [5:0] ext_rd_addr,
   output logic wr_strobe,
   output logic [5:0] wr_addr,
   output logic [23:0] wr_data,
   output logic sleep_mode,
   output logic auto_wake_en
);

   swmon_pkg::port_state_s s;
   swmon_pkg::port_state_s next_s;

   logic [swmon_pkg::SY_W-1:0] sy;
   logic [21:0] sw_now;
   logic cs_high;
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic [7:0] rx_crc;
   logic [7:0] tx_crc;
   logic [31:0] tx_word;
   logic [23:0] rd_value;
   logic [23:0] status_body;
   logic frame_ok;
   logic [5:0] rx_addr;
   logic [23:0] rx_data;
   logic [4:0] events;
   logic [4:0] kept;

   // Switch order matches the reply: high-supply, source-only, bidirectional
   level_sync #(
      .W(swmon_pkg::SY_W),
      .INIT(swmon_pkg::SY_INIT)
   ) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in({high_supply_inputs, source_only_inputs, bidir_current_inputs,
                 thermal_shutdown_in, test_mode_in, si, sclk, chip_select_n}),
      .sync_out(sy)
   );

   frame_crc8 u_rx_crc (
      .data(s.rx[39:8]),
      .crc(rx_crc)
   );

   frame_crc8 u_tx_crc (
      .data(tx_word),
      .crc(tx_crc)
   );

   assign sw_now = sy[swmon_pkg::SY_SW +: swmon_pkg::NUM_SW];
   assign cs_high = sy[swmon_pkg::SY_CS];
   assign cs_fall = s.cs_prev & ~cs_high;
   assign cs_rise = ~s.cs_prev & cs_high;
   // Clock edges only count inside a frame
   assign sclk_rise = ~cs_high & ~s.sclk_prev & sy[swmon_pkg::SY_SCLK];
   assign sclk_fall = ~cs_high & s.sclk_prev & ~sy[swmon_pkg::SY_SCLK];

   assign rx_addr = s.rx[37:32];
   assign rx_data = s.rx[31:8];
   assign frame_ok = (s.bit_cnt == swmon_pkg::FRAME_LEN)
                     && (s.rx[39:38] == swmon_pkg::DIR_HOST)
                     && (rx_crc == s.rx[7:0]);

   // Readback source: own control bits, else the outside register file
   always_comb
   begin
      rd_value = ext_rd_data;
      if (s.rd_addr == swmon_pkg::ADDR_MODE)
      begin
         rd_value = '0;
         rd_value[swmon_pkg::DATA_CTRL_BIT] = s.sleep;
      end
      else if (s.rd_addr == swmon_pkg::ADDR_AUTO)
      begin
         rd_value = '0;
         rd_value[swmon_pkg::DATA_CTRL_BIT] = s.auto_wake;
      end
   end

   // Floating inputs simply report the last value seen with source on
   assign status_body = {1'b0, s.sleep, s.sw_state};
   assign tx_word = s.rd_pending ? {swmon_pkg::REPLY_HEAD, s.flags, rd_value}
                                 : {swmon_pkg::REPLY_HEAD, s.flags, status_body};

   always_comb
   begin
      next_s = s;
      next_s.cs_prev = cs_high;
      next_s.sclk_prev = sy[swmon_pkg::SY_SCLK];
      next_s.wr_strobe = 1'b0;
      events = '0;
      kept = s.flags;

      // Fault levels keep their factor raised while present
      events[swmon_pkg::FLAG_TEST] = sy[swmon_pkg::SY_TEST];
      events[swmon_pkg::FLAG_THERM] = sy[swmon_pkg::SY_THERM];

      // Switch scan; only inputs with their source on are trusted
      for (int i = 0; i < swmon_pkg::NUM_SW; i++)
      begin
         if (source_on[i] && (sw_now[i] != s.sw_state[i]))
         begin
            next_s.sw_state[i] = sw_now[i];
            events[swmon_pkg::FLAG_SW] = 1'b1;
         end
      end
      if (events[swmon_pkg::FLAG_SW] && s.sleep && s.auto_wake)
      begin
         next_s.sleep = 1'b0;
      end

      // Frame start: freeze the reply and the factors it reports
      if (cs_fall)
      begin
         next_s.tx = {tx_word, tx_crc};
         next_s.so = tx_word[31];
         next_s.rep_flags = s.flags;
         next_s.bit_cnt = '0;
      end

      if (sclk_rise)
      begin
         next_s.so = s.tx[swmon_pkg::FRAME_BITS-1];
         next_s.tx = {s.tx[38:0], 1'b0};
      end

      if (sclk_fall)
      begin
         next_s.rx = {s.rx[38:0], sy[swmon_pkg::SY_SI]};
         if (s.bit_cnt != swmon_pkg::FRAME_CNT_MAX)
         begin
            next_s.bit_cnt = s.bit_cnt + 7'h01;
         end
      end

      // Frame end: act on a good frame, flag a bad one, clear what was seen
      if (cs_rise)
      begin
         kept = s.flags & ~s.rep_flags;
         next_s.rd_pending = 1'b0;
         if (!frame_ok)
         begin
            events[swmon_pkg::FLAG_ERR] = 1'b1;
         end
         else if (rx_addr[swmon_pkg::ADDR_READ_BIT])
         begin
            next_s.rd_pending = 1'b1;
            next_s.rd_addr = {1'b0, rx_addr[4:0]};
         end
         else if (rx_addr == swmon_pkg::ADDR_MODE)
         begin
            next_s.sleep = rx_data[swmon_pkg::DATA_CTRL_BIT];
         end
         else if (rx_addr == swmon_pkg::ADDR_AUTO)
         begin
            next_s.auto_wake = rx_data[swmon_pkg::DATA_CTRL_BIT];
         end
         else if (rx_addr != swmon_pkg::ADDR_NULL)
         begin
            next_s.wr_strobe = 1'b1;
            next_s.wr_addr = rx_addr;
            next_s.wr_data = rx_data;
         end
      end

      // New causes win over the clear in the same cycle
      next_s.flags = kept | events;
      next_s.int_oe = |next_s.flags;
      next_s.so_oe = ~cs_high;
      next_s.wake_oe = ~next_s.sleep;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s <= '0;
         s.cs_prev <= 1'b1;
         s.flags <= swmon_pkg::FLAGS_RESET;
         s.int_oe <= 1'b1;
         s.wake_oe <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign so = s.so;
   assign so_oe = s.so_oe;
   // Open-drain pins only ever drive low
   assign int_n_out = s.pin_low;
   assign int_n_oe = s.int_oe;
   assign wake_out_n = s.pin_low;
   assign wake_out_n_oe = s.wake_oe;
   assign ext_rd_addr = s.rd_addr;
   assign wr_strobe = s.wr_strobe;
   assign wr_addr = s.wr_addr;
   assign wr_data = s.wr_data;
   assign sleep_mode = s.sleep;
   assign auto_wake_en = s.auto_wake;

endmodule : switch_monitor_serial_frame_port

`default_nettype wire

// ---- swmon_host.sv ----
// Host side of the serial frame link: drives select, clock and data.
// Assumes calls start on a falling clk edge; sclk idles low.
`default_nettype none

module swmon_host (
   output var logic cs_n,
   output var logic sclk,
   output var logic si,
   input wire logic so
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end

   // MSB first; si changes on the rise, well clear of the sampling fall
   task automatic xfer(input logic [39:0] t, input int n, output logic [39:0] r);
      r = '0;
      cs_n = 1'b0;
      #80;
      for (int i = 39; i > 39 - n; i--)
      begin
         sclk = 1'b1;
         si = t[i];
         #80;
         r[i] = so;
         sclk = 1'b0;
         #80;
      end
      si = 1'b0;
      cs_n = 1'b1;
      #200;
   endtask : xfer

endmodule : swmon_host

`default_nettype wire

// ---- swmon_port_checker.sv ----
// Timing relations of the serial frame port, from its ports alone.
// Assumes one clk domain with synchronous active-high reset.
`default_nettype none

module swmon_port_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic chip_select_n,
   input wire logic sclk,
   input wire logic so,
   input wire logic so_oe,
   input wire logic int_n_oe,
   input wire logic wake_out_n_oe,
   input wire logic wr_strobe,
   input wire logic sleep_mode
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_cs_fall;
      $fell(chip_select_n);
   endsequence
   sequence s_frame_done;
      chip_select_n && $past(chip_select_n, 2);
   endsequence

   property p_oe_on;
      s_cs_fall |-> ##[2:5] so_oe;
   endproperty
   property p_oe_off;
      chip_select_n [*6] |-> !so_oe;
   endproperty
   property p_int_boot;
      $fell(sys_rst) |-> int_n_oe [*4];
   endproperty
   property p_int_clr;
      $fell(int_n_oe) |-> s_frame_done;
   endproperty
   property p_wake_sl;
      sleep_mode [*3] |-> !wake_out_n_oe;
   endproperty
   property p_wake_nm;
      !sleep_mode [*3] |-> wake_out_n_oe;
   endproperty
   property p_sleep_set;
      $rose(sleep_mode) |-> s_frame_done;
   endproperty
   property p_wr_pulse;
      wr_strobe |-> chip_select_n ##1 !wr_strobe;
   endproperty
   property p_so_edge;
      so_oe && $past(so_oe) && $changed(so) |-> $past(sclk, 2);
   endproperty

   a_oe_on: assert property (p_oe_on) else $error("so_oe late");
   a_oe_off: assert property (p_oe_off) else $error("so_oe while idle");
   a_int_boot: assert property (p_int_boot) else $error("no boot irq");
   a_int_clr: assert property (p_int_clr) else $error("irq freed early");
   a_wake_sl: assert property (p_wake_sl) else $error("wake driven");
   a_wake_nm: assert property (p_wake_nm) else $error("wake floats");
   a_sleep_set: assert property (p_sleep_set) else $error("sleep early");
   a_wr_pulse: assert property (p_wr_pulse) else $error("bad strobe");
   a_so_edge: assert property (p_so_edge) else $error("so moved");
endmodule : swmon_port_checker

bind switch_monitor_serial_frame_port swmon_port_checker u_chk (
   .clk(clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n), .sclk(sclk), .so(so),
   .so_oe(so_oe), .int_n_oe(int_n_oe), .wake_out_n_oe(wake_out_n_oe),
   .wr_strobe(wr_strobe), .sleep_mode(sleep_mode));

`default_nettype wire

// ---- switch_monitor_serial_frame_port_tb_top.sv ----
// Self-checking bench for the switch monitor serial frame port.
// Assumes swmon_host drives the link; switch levels come from sw.
`default_nettype none

module switch_monitor_serial_frame_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk;
   logic sys_rst;
   logic cs_n, sclk, si, so, so_oe, int_n_out, int_n_oe, wake_n, wake_oe;
   logic wr_strobe, sleep_mode, auto_wake_en;
   logic [21:0] sw;
   logic [21:0] src_on;
   logic test_in, therm_in, so_pin;
   logic [5:0] rd_addr, wr_addr;
   logic [23:0] wr_data;
   logic [39:0] r;
   int miscompares = 0;
   int checked = 0;

   // Undriven line reads as the inverse, so a late enable shows up
   assign so_pin = so_oe ? so : ~so;

   swmon_host host (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so_pin));

   switch_monitor_serial_frame_port dut (
      .clk(clk), .sys_rst(sys_rst), .chip_select_n(cs_n), .sclk(sclk), .si(si),
      .high_supply_inputs(sw[21:16]), .source_only_inputs(sw[15:8]),
      .bidir_current_inputs(sw[7:0]), .source_on(src_on), .test_mode_in(test_in),
      .thermal_shutdown_in(therm_in), .ext_rd_data({4{rd_addr}}), .so(so), .so_oe(so_oe),
      .int_n_out(int_n_out), .int_n_oe(int_n_oe), .wake_out_n(wake_n),
      .wake_out_n_oe(wake_oe), .ext_rd_addr(rd_addr), .wr_strobe(wr_strobe),
      .wr_addr(wr_addr), .wr_data(wr_data), .sleep_mode(sleep_mode),
      .auto_wake_en(auto_wake_en));

   task automatic stop_test;
      if (miscompares == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   task automatic cmp(input logic [39:0] g, input logic [39:0] e);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp

   task automatic cmp1(input logic g, input logic e);
      cmp({39'h0, g}, {39'h0, e});
   endtask : cmp1

   function automatic logic [39:0] seal(input logic [39:0] t);
      logic [7:0] c;
      c = swmon_pkg::CRC_INIT;
      for (int i = 39; i >= 8; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ t[i]) ? swmon_pkg::CRC_POLY : 8'h00);
      return {t[39:8], c};
   endfunction : seal

   function automatic logic [39:0] cmd(input logic [5:0] a, input logic [23:0] d);
      return seal({swmon_pkg::DIR_HOST, a, d, 8'h00});
   endfunction : cmd

   function automatic logic [39:0] nul();
      return cmd(swmon_pkg::ADDR_NULL, 24'h00_0000);
   endfunction : nul

   function automatic logic [39:0] st(input logic [4:0] f, input logic m);
      return seal({swmon_pkg::REPLY_HEAD, f, 1'b0, m, sw, 8'h00});
   endfunction : st

   function automatic logic [39:0] rb(input logic [4:0] f, input logic [23:0] v);
      return seal({swmon_pkg::REPLY_HEAD, f, v, 8'h00});
   endfunction : rb

   task automatic fr(input logic [39:0] t, input logic [39:0] e);
      host.xfer(t, 40, r);
      cmp(r, e);
   endtask : fr

   task automatic wait_int;
      int i;
      for (i = 0; i < 100 && int_n_oe !== 1'b1; i++)
         @(negedge clk);
      cmp1(int_n_oe, 1'b1);
      if (i == 100)
         stop_test();
   endtask : wait_int

   task automatic t_power;
      cmp1(int_n_oe, 1'b1);
      cmp1(wake_oe, 1'b1);
      cmp1(so_oe, 1'b0);
      cmp1(int_n_out, 1'b0);
      cmp1(wake_n, 1'b0);
      fr(nul(), st(5'h05, 1'b0));
      cmp1(int_n_oe, 1'b0);
   endtask : t_power

   // Switch moves mid-frame: reply keeps the snapshot, factor waits
   task automatic t_change;
      logic [39:0] e;
      e = st(5'h00, 1'b0);
      fork
         host.xfer(nul(), 40, r);
         begin
            repeat (400) @(negedge clk);
            sw = sw ^ 22'h20_0101;
         end
      join
      cmp(r, e);
      cmp1(int_n_oe, 1'b1);
      fr(nul(), st(5'h01, 1'b0));
      cmp1(int_n_oe, 1'b0);
   endtask : t_change

   task automatic t_error;
      logic [39:0] b;
      for (int k = 0; k < 3; k++)
      begin
         b = cmd(swmon_pkg::ADDR_MODE, 24'h80_0000);
         if (k == 0)
            b[0] = ~b[0];
         if (k == 1)
            b = seal({2'h2, b[37:0]});
         host.xfer(b, (k == 2) ? 39 : 40, r);
         cmp1(sleep_mode, 1'b0);
         fr(nul(), st(5'h02, 1'b0));
      end
   endtask : t_error

   task automatic t_mode;
      host.xfer(cmd(swmon_pkg::ADDR_MODE, 24'h80_0000), 40, r);
      cmp1(sleep_mode, 1'b1);
      cmp1(wake_oe, 1'b0);
      fr(nul(), st(5'h00, 1'b1));
      host.xfer(cmd(swmon_pkg::ADDR_MODE, 24'h00_0000), 40, r);
      cmp1(sleep_mode, 1'b0);
      host.xfer(cmd(swmon_pkg::ADDR_AUTO, 24'h80_0000), 40, r);
      cmp1(auto_wake_en, 1'b1);
      host.xfer(cmd(swmon_pkg::ADDR_MODE, 24'h80_0000), 40, r);
      sw = sw ^ 22'h00_0400;
      wait_int();
      repeat (4) @(negedge clk);
      cmp1(sleep_mode, 1'b0);
      cmp1(wake_oe, 1'b1);
      fr(nul(), st(5'h01, 1'b0));
   endtask : t_mode

   // Source off hides a switch; fault levels latch their factors
   task automatic t_fault;
      logic [39:0] e;
      e = st(5'h00, 1'b0);
      src_on = 22'h3F_FBFF;
      sw = sw ^ 22'h00_0400;
      repeat (20) @(negedge clk);
      cmp1(int_n_oe, 1'b0);
      fr(nul(), e);
      src_on = 22'h3F_FFFF;
      test_in = 1'b1;
      therm_in = 1'b1;
      wait_int();
      repeat (4) @(negedge clk);
      test_in = 1'b0;
      therm_in = 1'b0;
      repeat (4) @(negedge clk);
      fr(nul(), st(5'h19, 1'b0));
      cmp1(int_n_oe, 1'b0);
   endtask : t_fault

   task automatic t_read;
      host.xfer(cmd(6'h05, 24'h12_3456), 40, r);
      cmp({10'h000, wr_addr, wr_data}, {10'h000, 6'h05, 24'h12_3456});
      fr(cmd(6'h21, 24'h00_0000), st(5'h00, 1'b0));
      fr(cmd(6'h23, 24'h00_0000), rb(5'h00, {4{6'h01}}));
      fr(nul(), rb(5'h00, {4{6'h03}}));
   endtask : t_read

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial
   begin
      sys_rst = 1'b1;
      sw = 22'h15_A5C3;
      src_on = 22'h3F_FFFF;
      test_in = 1'b0;
      therm_in = 1'b0;
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      repeat (20) @(negedge clk);
      t_power();
      t_change();
      t_error();
      t_mode();
      t_fault();
      t_read();
      stop_test();
   end
endmodule : switch_monitor_serial_frame_port_tb_top

`default_nettype wire
